// ---- test/lpmc_ctrl_asserts.sv ----
`timescale 1ns/1ps
module lpmc_ctrl_asserts #(
  parameter int OSC_CYC = 2
) (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  wait_for_interrupt,
  input wire logic                  wait_for_event,
  input wire logic                  handler_exit,
  input wire logic                  sleep_on_handler_exit,
  input wire logic                  deep_sleep_select,
  input wire logic                  irq_pending,
  input wire logic                  event_in,
  input wire lpmc_pkg::lpmc_power_s power,
  input wire logic                  core_run,
  input wire logic                  service_irq,
  input wire logic                  resume_from_reset,
  input wire logic [1:0]            mode_active
);
  import lpmc_pkg::*;
  logic       evt_reg, evt_next, take, cause;
  logic [1:0] md_reg, md_next;
  logic [7:0] wk_reg, wk_next;
  // handler exit entry counts as an interrupt-wait entry
  assign take  = core_run && (sleep_on_handler_exit ? handler_exit : wait_for_interrupt || wait_for_event);
  assign cause = evt_reg ? event_in : irq_pending;
  // mode kept from the last asleep cycle, so it is still valid on the wake edge
  always_comb begin
    evt_next = take ? wait_for_event && !sleep_on_handler_exit : evt_reg;
    md_next  = core_run ? md_reg : mode_active;
    wk_next  = core_run ? 8'h00 : wk_reg + 8'(cause || wk_reg != 8'h00);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_reg <= 1'h0;
      md_reg  <= 2'h0;
      wk_reg  <= 8'h00;
    end else begin
      evt_reg <= evt_next;
      md_reg  <= md_next;
      wk_reg  <= wk_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_sleep_entry: assert property (
    take && !deep_sleep_select |=> !core_run && !power.core_clk_en && power.periph_clk_en
  ) else $error("sleep entry wrong");
  chk_stop_halt: assert property (
    $fell(core_run) && mode_active == LPMC_STOP |-> !power.periph_clk_en && !power.core_clk_en
  ) else $error("stop entry wrong");
  chk_sleep_wake: assert property (
    !core_run && mode_active == LPMC_SLEEP && cause |=> core_run && service_irq == !evt_reg
  ) else $error("sleep wake wrong");
  chk_sleep_hold: assert property (
    !core_run && mode_active == LPMC_SLEEP && !cause |=> !core_run
  ) else $error("sleep left early");
  chk_stop_delay: assert property (
    $rose(core_run) && md_reg == LPMC_STOP |-> wk_reg >= OSC_CYC && service_irq == !evt_reg
  ) else $error("stop wake too early");
  chk_run_clocks: assert property (
    $rose(core_run) |-> power.core_clk_en && power.periph_clk_en && power.fast_osc_en && !power.reg_low_power
  ) else $error("clocks not restored");
  chk_sb_power: assert property (
    $fell(core_run) && mode_active == LPMC_STANDBY |-> !power.domain_power_on && !power.reg_on && power.core_reset
  ) else $error("standby power wrong");
  chk_sb_resume: assert property (
    resume_from_reset |-> md_reg == LPMC_STANDBY && !service_irq
  ) else $error("resume outside standby");
  cover property ($rose(core_run) && md_reg == LPMC_STOP);
  cover property (resume_from_reset);
  cover property (take && sleep_on_handler_exit);
endmodule : lpmc_ctrl_asserts
bind lpmc_ctrl lpmc_ctrl_asserts #(.OSC_CYC(OSC_CYC)) u_lpmc_ctrl_asserts (
  .clk, .rstn, .wait_for_interrupt, .wait_for_event, .handler_exit, .sleep_on_handler_exit,
  .deep_sleep_select, .irq_pending, .event_in, .power, .core_run, .service_irq, .resume_from_reset, .mode_active
);

// ---- test/lpmc_ctrl_bench.sv ----
`timescale 1ns/1ps
module lpmc_ctrl_bench;
  import lpmc_pkg::*;
  localparam int OSC_N = 2;
  localparam int REG_N = 3;
  localparam int RSW_N = 4;
  logic        clk, rstn, wr, rd, wait_for_interrupt, wait_for_event, handler_exit, irq_req;
  logic        sleep_on_handler_exit, deep_sleep_select, irq_pending, event_in, pvd_below;
  logic        core_run, service_irq, resume_from_reset, sv, sr, bwe, lpa;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [1:0]  mode_active;
  lpmc_wake_s  wake;
  lpmc_power_s power;
  int          err_total, cmp_count, cyc, n, nr;
  lpmc_ctrl #(.OSC_CYC(OSC_N), .REG_CYC(REG_N), .RESET_CYC(RSW_N)) u_lpmc_ctrl (
    .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .wait_for_interrupt, .wait_for_event, .handler_exit,
    .sleep_on_handler_exit, .deep_sleep_select, .irq_pending, .event_in, .wake, .pvd_below, .power,
    .core_run, .service_irq, .resume_from_reset, .backup_write_en(bwe), .mode_active, .low_power_active(lpa)
  );
  lpmc_irq_model u_lpmc_irq_model (.clk, .rstn, .irq_req, .service_irq, .irq_pending);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask : bw
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(nm, rdata & m, exp);
  endtask : rc
  task automatic go(input logic i, input logic e, input logic h);
    @(posedge clk);
    wait_for_interrupt <= i;
    wait_for_event     <= e;
    handler_exit       <= h;
    @(posedge clk);
    {wait_for_interrupt, wait_for_event, handler_exit} <= 3'h0;
    #1;
  endtask : go
  // event and pin wake causes are dropped after two cycles and the interrupt request after one, so a held level cannot mask a slow wake
  task automatic wake_up;
    n  = 0;
    nr = 0;
    sr = 1'h0;
    while (core_run !== 1'h1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      nr += int'(power.core_reset);
      sr |= resume_from_reset;
      irq_req <= 1'h0;
      if (n == 2) begin
        wake     <= 5'h02;
        event_in <= 1'h0;
      end
    end
    sv = service_irq;
    @(posedge clk);
    #1;
    sr |= resume_from_reset;
  endtask : wake_up
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {rstn, wr, rd, wait_for_interrupt, wait_for_event, handler_exit, irq_req} = 7'h00;
    {sleep_on_handler_exit, deep_sleep_select, event_in, pvd_below, addr, wdata} = 44'h0;
    wake = 5'h02;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    rc("ctrl rst", 8'h00, 32'hFFFFFFFF, 32'h0);
    bw(8'h08, 32'hFFFFFFFF);
    rc("unmapped", 8'h08, 32'hFFFFFFFF, 32'h0);
    rc("stat rst", 8'h04, 32'hFFFFFFFF, 32'h0);
    bw(8'h00, 32'hFFFFFFFF);
    rc("ctrl rw", 8'h00, 32'hFFFFFFFF, 32'h1F3);
    bw(8'h00, 32'h0);
    go(1'h1, 1'h0, 1'h0);
    chk("sleep", {core_run, lpa, power.core_clk_en, power.periph_clk_en, power.reg_low_power}, 5'h0A);
    event_in <= 1'h1;
    repeat (3) @(posedge clk);
    event_in <= 1'h0;
    #1;
    chk("irq entry on event", core_run, 1'h0);
    irq_req <= 1'h1;
    wake_up();
    chk("sleep wake", {n <= 3, sv}, 2'h3);
    go(1'h0, 1'h1, 1'h0);
    irq_req <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("event entry on irq", core_run, 1'h0);
    event_in <= 1'h1;
    wake_up();
    chk("event wake", {n <= 3, sv}, 2'h2);
    sleep_on_handler_exit <= 1'h1;
    go(1'h1, 1'h0, 1'h0);
    chk("wait ignored", core_run, 1'h1);
    go(1'h0, 1'h0, 1'h1);
    chk("exit sleep", core_run, 1'h0);
    wake_up();
    chk("exit wake", sv, 1'h1);
    sleep_on_handler_exit <= 1'h0;
    deep_sleep_select     <= 1'h1;
    for (int lp = 0; lp < 2; lp++) begin
      bw(8'h00, 32'(lp));
      go(1'h1, 1'h0, 1'h0);
      bw(8'h00, 32'h2);
      chk("stop", {mode_active, power.reg_low_power, power.periph_clk_en}, {2'h1, 1'(lp), 1'h0});
      irq_req <= 1'h1;
      wake_up();
      chk("stop wake", {n >= OSC_N + REG_N * lp, sv, power.periph_clk_en}, 3'h7);
    end
    for (int k = 0; k < 5; k++) begin
      bw(8'h00, 32'h106);
      bw(8'h04, 32'h0);
      go(1'h1, 1'h0, 1'h0);
      chk("standby", {mode_active, power.domain_power_on, bwe}, 4'h9);
      if (k == 0) begin
        wake.wake_pin <= 1'h1;
        repeat (3) @(posedge clk);
        wake.wake_pin <= 1'h0;
        repeat (3) @(posedge clk);
        #1;
        chk("pin as io", {core_run, power.core_reset}, 2'h1);
        bw(8'h04, 32'h100);
      end
      wake <= 5'h02 ^ (5'h10 >> k);
      wake_up();
      chk("reset wait", {nr >= RSW_N, sr, sv, bwe}, 4'hC);
      rc("ctrl after", 8'h00, 32'hFFFFFFFF, 32'h0);
    end
    bw(8'h04, 32'h100);
    wake      <= 5'h12;
    pvd_below <= 1'h1;
    bw(8'h00, 32'h12);
    wake <= 5'h02;
    rc("flags", 8'h04, 32'hFFFFFFFF, 32'h107);
    go(1'h1, 1'h0, 1'h0);
    chk("no standby", core_run, 1'h1);
    bw(8'h00, 32'hE);
    rc("flag hold", 8'h04, 32'h1, 32'h1);
    rc("flag clear", 8'h04, 32'hFFFFFFFF, 32'h100);
    end_sim();
  end
endmodule : lpmc_ctrl_bench

// ---- test/lpmc_irq_model.sv ----
`timescale 1ns/1ps
module lpmc_irq_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic irq_req,
  input  wire logic service_irq,
  output logic      irq_pending
);
  logic pend_reg, pend_next;
  assign irq_pending = pend_reg;
  // a request stays pending until the core enters its handler
  always_comb begin
    pend_next = (pend_reg && !service_irq) || irq_req;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'h0;
    end else begin
      pend_reg <= pend_next;
    end
  end
endmodule : lpmc_irq_model

// ---- verilog/lpmc_ctrl.sv ----
// Chosen here: strobed register access.
`timescale 1ns/1ps
module lpmc_ctrl #(
  parameter int OSC_CYC   = lpmc_pkg::OSC_START_CYC,
  parameter int REG_CYC   = lpmc_pkg::REG_WAKE_CYC,
  parameter int RESET_CYC = lpmc_pkg::CHIP_RESET_CYC
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  input  wire logic               wait_for_interrupt,
  input  wire logic               wait_for_event,
  input  wire logic               handler_exit,
  input  wire logic               sleep_on_handler_exit,
  input  wire logic               deep_sleep_select,
  input  wire logic               irq_pending,
  input  wire logic               event_in,
  input  wire lpmc_pkg::lpmc_wake_s wake,
  input  wire logic               pvd_below,
  output lpmc_pkg::lpmc_power_s   power,
  output logic                    core_run,
  output logic                    service_irq,
  output logic                    resume_from_reset,
  output logic                    backup_write_en,
  output logic [1:0]              mode_active,
  output logic                    low_power_active
);
  import lpmc_pkg::*;
  localparam int DW = 16;
  typedef enum {ST_RUN, ST_SLEEP, ST_STOP, ST_STOP_WAKE, ST_STANDBY, ST_RESET_WAIT} lpmc_state_e;

  lpmc_state_e state_reg;
  lpmc_state_e state_next;
  logic [8:0]  ctrl_reg;
  logic [8:0]  ctrl_next;
  logic        wuef_reg;
  logic        wuef_next;
  logic        sbf_reg;
  logic        sbf_next;
  logic        wkpsel_reg;
  logic        wkpsel_next;
  logic [1:0]  wuclr_pipe_reg;
  logic [1:0]  wuclr_pipe_next;
  logic        by_event_reg;
  logic        by_event_next;
  logic        lpreg_hold_reg;
  logic        lpreg_hold_next;
  lpmc_mode_e  mode_reg;
  lpmc_mode_e  mode_next;
  logic        svc_reg;
  logic        svc_next;
  logic        rst_entry_reg;
  logic        rst_entry_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        pin_rise;
  logic        dly_start;
  logic [DW-1:0] dly_count;
  logic        dly_busy;
  logic        dly_done;
  logic        enter;
  logic        wake_hit;
  logic        standby_wake;

  lpmc_edge u_pin (
    .clk   (clk),
    .rstn  (rstn),
    .level (wake.wake_pin),
    .rise  (pin_rise)
  );

  lpmc_delay #(.W(DW)) u_dly (
    .clk   (clk),
    .rstn  (rstn),
    .start (dly_start),
    .count (dly_count),
    .busy  (dly_busy),
    .done  (dly_done)
  );

  // entry on a wait instruction when that option is clear, or only on handler exit when it is set
  assign enter = (wait_for_interrupt | wait_for_event) & ~sleep_on_handler_exit
               | handler_exit & sleep_on_handler_exit;
  // interrupt-wait entry accepts any interrupt; event-wait entry accepts only events
  assign wake_hit = by_event_reg ? event_in : irq_pending;
  assign standby_wake = (pin_rise & wkpsel_reg) | wake.rtc_alarm | wake.tamper
                      | ~wake.ext_reset_n | wake.watchdog_reset;

  always_comb begin
    state_next      = state_reg;
    mode_next       = mode_reg;
    by_event_next   = by_event_reg;
    lpreg_hold_next = lpreg_hold_reg;
    svc_next        = 1'b0;
    rst_entry_next  = 1'b0;
    dly_start       = 1'b0;
    dly_count       = '0;
    case (state_reg)
      ST_RUN: begin
        if (enter) begin
          // choice is frozen here so software writes cannot disturb the sleep
          by_event_next   = wait_for_event & ~sleep_on_handler_exit;
          lpreg_hold_next = ctrl_reg[CTRL_LPREG];
          if (!deep_sleep_select) begin
            mode_next  = LPMC_SLEEP;
            state_next = ST_SLEEP;
          end else if (!ctrl_reg[CTRL_PDSEL]) begin
            mode_next  = LPMC_STOP;
            state_next = ST_STOP;
          end else if (!wuef_reg) begin
            mode_next  = LPMC_STANDBY;
            state_next = ST_STANDBY;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_next = ST_RUN;
          svc_next   = ~by_event_reg;
        end
      end
      ST_STOP: begin
        if (wake_hit) begin
          state_next = ST_STOP_WAKE;
          dly_start  = 1'b1;
          dly_count  = DW'(OSC_CYC + (lpreg_hold_reg ? REG_CYC : 0));
        end
      end
      ST_STOP_WAKE: begin
        if (dly_done) begin
          state_next = ST_RUN;
          svc_next   = ~by_event_reg;
        end
      end
      ST_STANDBY: begin
        if (standby_wake) begin
          state_next = ST_RESET_WAIT;
          dly_start  = 1'b1;
          dly_count  = DW'(RESET_CYC);
        end
      end
      default: begin
        if (dly_done) begin
          state_next     = ST_RUN;
          rst_entry_next = 1'b1;
        end
      end
    endcase
  end

  // register file
  always_comb begin
    ctrl_next       = ctrl_reg;
    wkpsel_next     = wkpsel_reg;
    wuef_next       = wuef_reg;
    sbf_next        = sbf_reg;
    wuclr_pipe_next = {wuclr_pipe_reg[0], 1'b0};
    rdata_next      = '0;
    // standby wake clears the control register but not the status one
    if (state_reg == ST_RESET_WAIT && dly_done) begin
      ctrl_next = CTRL_RESET;
    end
    if (wr && addr == ADDR_CTRL) begin
      ctrl_next[CTRL_LPREG]             = wdata[CTRL_LPREG];
      ctrl_next[CTRL_PDSEL]             = wdata[CTRL_PDSEL];
      ctrl_next[CTRL_VDET_EN]                  = wdata[CTRL_VDET_EN];
      ctrl_next[CTRL_VDET_LVL+2:CTRL_VDET_LVL] = wdata[CTRL_VDET_LVL+2:CTRL_VDET_LVL];
      ctrl_next[CTRL_BKP_WR]                   = wdata[CTRL_BKP_WR];
      wuclr_pipe_next[0]                = wdata[CTRL_WUCLR];
      if (wdata[CTRL_SBCLR]) begin
        sbf_next = 1'b0;
      end
    end else if (wr && addr == ADDR_STAT) begin
      wkpsel_next = wdata[STAT_WKPSEL];
    end
    if (state_reg == ST_RUN && enter && deep_sleep_select && ctrl_reg[CTRL_PDSEL] && !wuef_reg) begin
      sbf_next = 1'b1;
    end
    if (wuclr_pipe_reg[1]) begin
      wuef_next = 1'b0;
    end
    // a wake event in the clear cycle wins
    if ((wake.wake_pin && wkpsel_reg) || wake.rtc_alarm) begin
      wuef_next = 1'b1;
    end
    if (rd) begin
      if (addr == ADDR_CTRL) begin
        rdata_next[8:0] = ctrl_reg;
      end else if (addr == ADDR_STAT) begin
        rdata_next[STAT_WUEF]   = wuef_reg;
        rdata_next[STAT_SBF]    = sbf_reg;
        rdata_next[STAT_VDET_OUT] = pvd_below & ctrl_reg[CTRL_VDET_EN] & (state_reg != ST_STANDBY);
        rdata_next[STAT_WKPSEL] = wkpsel_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_RUN;
      mode_reg       <= LPMC_SLEEP;
      by_event_reg   <= 1'b0;
      lpreg_hold_reg <= 1'b0;
      svc_reg        <= 1'b0;
      rst_entry_reg  <= 1'b0;
      ctrl_reg       <= CTRL_RESET;
      wuef_reg       <= 1'b0;
      sbf_reg        <= 1'b0;
      wkpsel_reg     <= 1'b0;
      wuclr_pipe_reg <= 2'h0;
      rdata_reg      <= 32'h0;
    end else begin
      state_reg      <= state_next;
      mode_reg       <= mode_next;
      by_event_reg   <= by_event_next;
      lpreg_hold_reg <= lpreg_hold_next;
      svc_reg        <= svc_next;
      rst_entry_reg  <= rst_entry_next;
      ctrl_reg       <= ctrl_next;
      wuef_reg       <= wuef_next;
      sbf_reg        <= sbf_next;
      wkpsel_reg     <= wkpsel_next;
      wuclr_pipe_reg <= wuclr_pipe_next;
      rdata_reg      <= rdata_next;
    end
  end

  // clock and supply controls per state
  always_comb begin
    power = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, fast_osc_en: 1'b1, reg_on: 1'b1,
              reg_low_power: 1'b0, domain_power_on: 1'b1, core_reset: 1'b0};
    case (state_reg)
      ST_SLEEP: begin
        power.core_clk_en = 1'b0;
      end
      ST_STOP: begin
        power.core_clk_en   = 1'b0;
        power.periph_clk_en = 1'b0;
        power.fast_osc_en   = 1'b0;
        power.reg_low_power = lpreg_hold_reg;
      end
      ST_STOP_WAKE: begin
        // clocks come back only when oscillator and regulator have settled
        power.core_clk_en   = 1'b0;
        power.periph_clk_en = 1'b0;
      end
      ST_STANDBY: begin
        power.core_clk_en     = 1'b0;
        power.periph_clk_en   = 1'b0;
        power.fast_osc_en     = 1'b0;
        power.reg_on          = 1'b0;
        power.domain_power_on = 1'b0;
        power.core_reset      = 1'b1;
      end
      ST_RESET_WAIT: begin
        power.core_clk_en   = 1'b0;
        power.periph_clk_en = 1'b0;
        power.core_reset    = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign core_run          = (state_reg == ST_RUN);
  assign service_irq       = svc_reg;
  assign resume_from_reset = rst_entry_reg;
  assign backup_write_en   = ctrl_reg[CTRL_BKP_WR];
  assign mode_active       = mode_reg;
  assign low_power_active  = (state_reg != ST_RUN);
  assign rdata             = rdata_reg;
endmodule : lpmc_ctrl

// ---- verilog/lpmc_delay.sv ----
`timescale 1ns/1ps
module lpmc_delay #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              busy,
  output logic              done
);
  import lpmc_pkg::*;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         busy_reg;
  logic         busy_next;
  logic         done_next;
  logic         done_reg;
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next  = count;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg <= W'(1)) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
  assign busy = busy_reg;
  assign done = done_reg;
endmodule : lpmc_delay

// ---- verilog/lpmc_edge.sv ----
`timescale 1ns/1ps
module lpmc_edge (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic level,
  output logic      rise
);
  import lpmc_pkg::*;
  logic last_reg;
  logic last_next;
  always_comb begin
    last_next = level;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
    end
  end
  assign rise = level & ~last_reg;
endmodule : lpmc_edge

// ---- verilog/lpmc_pkg.sv ----
package lpmc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_LPREG   = 0;
  localparam int CTRL_PDSEL   = 1;
  localparam int CTRL_WUCLR   = 2;
  localparam int CTRL_SBCLR   = 3;
  localparam int CTRL_VDET_EN  = 4;
  localparam int CTRL_VDET_LVL = 5;
  localparam int CTRL_BKP_WR   = 8;
  localparam int STAT_WUEF    = 0;
  localparam int STAT_SBF     = 1;
  localparam int STAT_VDET_OUT = 2;
  localparam int STAT_WKPSEL  = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam int CLK_MHZ       = 50;
  localparam int OSC_START_NS  = 2000;
  localparam int REG_WAKE_NS   = 5000;
  localparam int CHIP_RESET_NS = 20000;
  localparam int OSC_START_CYC  = (OSC_START_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_WAKE_CYC   = (REG_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CHIP_RESET_CYC = (CHIP_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int WUCLR_DELAY    = 2;
  typedef enum logic [1:0] {LPMC_SLEEP, LPMC_STOP, LPMC_STANDBY} lpmc_mode_e;
  typedef struct packed {
    logic wake_pin;
    logic rtc_alarm;
    logic tamper;
    logic ext_reset_n;
    logic watchdog_reset;
  } lpmc_wake_s;
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic fast_osc_en;
    logic reg_on;
    logic reg_low_power;
    logic domain_power_on;
    logic core_reset;
  } lpmc_power_s;
endpackage : lpmc_pkg
